// File: common/acbi_defines.svh
// Purpose: Timing counts and widths for the converter host controller.
// Assumes: mclk at 100 MHz.
// Notes: Times in ns; cycle counts derived from them.
`ifndef ACBI_DEFINES_SVH
`define ACBI_DEFINES_SVH

// =============================================
// Clock and widths
// =============================================
`define ACBI_CLK_PERIOD_NS 10
`define ACBI_RESULT_W 10
`define ACBI_CHAN_W 2

// =============================================
// Times
// =============================================
`define ACBI_SAMPLE_MIN_NS 250
`define ACBI_SAMPLE_CYC ((`ACBI_SAMPLE_MIN_NS + `ACBI_CLK_PERIOD_NS - 1) / `ACBI_CLK_PERIOD_NS)
`define ACBI_DATA_SETTLE_NS 20
`define ACBI_SETTLE_CYC ((`ACBI_DATA_SETTLE_NS + `ACBI_CLK_PERIOD_NS - 1) / `ACBI_CLK_PERIOD_NS)
`define ACBI_READ_HOLD_NS 50
`define ACBI_READ_CYC ((`ACBI_READ_HOLD_NS + `ACBI_CLK_PERIOD_NS - 1) / `ACBI_CLK_PERIOD_NS)
`define ACBI_DONE_TIMEOUT_NS 2000
`define ACBI_TIMEOUT_CYC (`ACBI_DONE_TIMEOUT_NS / `ACBI_CLK_PERIOD_NS)
`define ACBI_CNT_W 8

`endif

// File: common/acbi_pkg.sv
// Purpose: Types for the converter host controller.
// Assumes: Nothing beyond the defines header.
// Notes: Sequencer states only.
package acbi_pkg;
    typedef enum logic [2:0] {
        ACBI_IDLE,
        ACBI_SAMPLE,
        ACBI_WAIT_DONE,
        ACBI_SETTLE,
        ACBI_READ,
        ACBI_RELEASE
    } acbi_state_e;
endpackage : acbi_pkg

// File: common/acbi_sync_if.sv
// Purpose: Carries raw pin levels into the synchroniser and clean levels back.
// Assumes: One clock.
// Notes: Bus and done travel together so they stay aligned.
`timescale 1ns/1ns
`include "acbi_defines.svh"
interface acbi_sync_if;
    logic done_raw_n;
    logic [`ACBI_RESULT_W-1:0] bus_raw;
    logic done_n;
    logic [`ACBI_RESULT_W-1:0] bus;
    modport sync (input done_raw_n, input bus_raw, output done_n, output bus);
    modport user (output done_raw_n, output bus_raw, input done_n, input bus);
endinterface : acbi_sync_if

// File: logic/acbi_sync.sv
// Purpose: Two-flop synchroniser for converter output pins.
// Assumes: Pins are asynchronous to mclk.
// Notes: Data bus is only trusted after the settle or read wait, so skew between bits is harmless.
`timescale 1ns/1ns
`include "acbi_defines.svh"
module acbi_sync (
    input wire logic mclk,
    input wire logic rst,
    acbi_sync_if.sync sig
);
    logic [`ACBI_RESULT_W:0] stage1;
    logic [`ACBI_RESULT_W:0] stage2;

    // =============================================
    // Double flop
    // =============================================
    always_ff @(posedge mclk) begin
        if (rst) begin
            stage1 <= {1'b1, {`ACBI_RESULT_W{1'b0}}};
            stage2 <= {1'b1, {`ACBI_RESULT_W{1'b0}}};
        end else begin
            stage1 <= {sig.done_raw_n, sig.bus_raw};
            stage2 <= stage1;
        end
    end

    assign sig.done_n = stage2[`ACBI_RESULT_W];
    assign sig.bus = stage2[`ACBI_RESULT_W-1:0];
endmodule : acbi_sync

// File: logic/acbi_host.sv
// Purpose: Host that starts conversions on the converter and reads the result bus.
// Assumes: mclk 100 MHz, synchronous active-high rst, converter pins asynchronous.
// Notes: Separate-strobe or tied-strobe sequencing chosen by tied_mode at start.
//
// Contract
// - Select lines are set before sample strobe falls and held through it.
// - Sample strobe is held low at least 250 ns in separate mode.
// - Chip select is held low whenever sample or read strobe is low.
// - Tied mode drives sample and read strobes low together.
`timescale 1ns/1ns
`include "acbi_defines.svh"
module acbi_host #(
    parameter int TIMEOUT_CYC = `ACBI_TIMEOUT_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic start,
    input wire logic tied_mode,
    input wire logic [`ACBI_CHAN_W-1:0] channel,
    output logic busy,
    output logic result_valid,
    output logic [`ACBI_RESULT_W-1:0] result,
    output logic timeout,
    output logic chip_select_n,
    output logic sample_hold_n,
    output logic read_n,
    output logic channel_select_lo,
    output logic channel_select_hi,
    input wire logic done_n,
    input wire logic [`ACBI_RESULT_W-1:0] result_bus
);
    acbi_pkg::acbi_state_e state;
    logic [`ACBI_CNT_W-1:0] cnt;
    logic [15:0] wait_cnt;
    logic tied;
    logic done_seen;
    acbi_sync_if sig ();

    assign sig.done_raw_n = done_n;
    assign sig.bus_raw = result_bus;

    acbi_sync u_sync (
        .mclk(mclk),
        .rst(rst),
        .sig(sig)
    );

    // =============================================
    // Sequencer
    // =============================================
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= acbi_pkg::ACBI_IDLE;
            cnt <= '0;
            tied <= 1'b0;
        end else begin
            case (state)
                acbi_pkg::ACBI_IDLE: begin
                    cnt <= '0;
                    if (start && sig.done_n) begin
                        tied <= tied_mode;
                        state <= acbi_pkg::ACBI_SAMPLE;
                    end
                end
                acbi_pkg::ACBI_SAMPLE: begin
                    cnt <= cnt + 8'h01;
                    if (tied) begin
                        state <= acbi_pkg::ACBI_WAIT_DONE;
                    // The strobe only falls one cycle into this state, so the count runs one
                    // further to keep it low for the whole minimum sampling time.
                    end else if (cnt == 8'(`ACBI_SAMPLE_CYC)) begin
                        state <= acbi_pkg::ACBI_WAIT_DONE;
                    end
                end
                acbi_pkg::ACBI_WAIT_DONE: begin
                    cnt <= '0;
                    if (!sig.done_n) begin
                        state <= tied ? acbi_pkg::ACBI_SETTLE : acbi_pkg::ACBI_READ;
                    end else if (timeout) begin
                        state <= acbi_pkg::ACBI_RELEASE;
                    end
                end
                acbi_pkg::ACBI_SETTLE: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == 8'(`ACBI_SETTLE_CYC - 1)) begin
                        state <= acbi_pkg::ACBI_RELEASE;
                    end
                end
                acbi_pkg::ACBI_READ: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == 8'(`ACBI_READ_CYC + 1)) begin
                        state <= acbi_pkg::ACBI_RELEASE;
                    end
                end
                acbi_pkg::ACBI_RELEASE: begin
                    if (sig.done_n) begin
                        state <= acbi_pkg::ACBI_IDLE;
                    end
                end
                default: begin
                    state <= acbi_pkg::ACBI_IDLE;
                end
            endcase
        end
    end

    // =============================================
    // Done timeout watchdog
    // =============================================
    always_ff @(posedge mclk) begin
        if (rst) begin
            wait_cnt <= '0;
        end else if (state == acbi_pkg::ACBI_WAIT_DONE) begin
            if (!timeout) begin
                wait_cnt <= wait_cnt + 16'h0001;
            end
        end else begin
            wait_cnt <= '0;
        end
    end
    // A lost done would otherwise hang the host; the watchdog frees it.
    assign timeout = (wait_cnt >= 16'(TIMEOUT_CYC));

    // =============================================
    // Pins
    // =============================================
    always_ff @(posedge mclk) begin
        if (rst) begin
            chip_select_n <= 1'b1;
            sample_hold_n <= 1'b1;
            read_n <= 1'b1;
            channel_select_lo <= 1'b0;
            channel_select_hi <= 1'b0;
        end else begin
            if (state == acbi_pkg::ACBI_IDLE && start && sig.done_n) begin
                channel_select_lo <= channel[0];
                channel_select_hi <= channel[1];
            end
            // Select lines go out two cycles before the strobe so they meet setup.
            chip_select_n <= !(state == acbi_pkg::ACBI_SAMPLE || state == acbi_pkg::ACBI_WAIT_DONE
                || state == acbi_pkg::ACBI_SETTLE || state == acbi_pkg::ACBI_READ);
            sample_hold_n <= !(state == acbi_pkg::ACBI_SAMPLE && cnt != 8'h00
                || tied && (state == acbi_pkg::ACBI_WAIT_DONE
                || state == acbi_pkg::ACBI_SETTLE));
            read_n <= !(state == acbi_pkg::ACBI_READ
                || tied && (state == acbi_pkg::ACBI_WAIT_DONE
                || state == acbi_pkg::ACBI_SETTLE));
        end
    end

    // =============================================
    // Result capture
    // =============================================
    always_ff @(posedge mclk) begin
        if (rst) begin
            result <= '0;
            result_valid <= 1'b0;
            done_seen <= 1'b0;
        end else begin
            result_valid <= 1'b0;
            done_seen <= (state == acbi_pkg::ACBI_RELEASE);
            if ((state == acbi_pkg::ACBI_SETTLE && cnt == 8'(`ACBI_SETTLE_CYC - 1))
                || (state == acbi_pkg::ACBI_READ && cnt == 8'(`ACBI_READ_CYC + 1))) begin
                if (!read_n && !chip_select_n) begin
                    result <= sig.bus;
                    result_valid <= 1'b1;
                end
            end
        end
    end

    assign busy = (state != acbi_pkg::ACBI_IDLE) || done_seen;
endmodule : acbi_host

// File: verif/acbi_dev_model.sv
// Purpose: Behavioural converter that answers the host pins.
// Assumes: Pins change at host clock edges.
// Notes: Codes per channel come from the bench.
`timescale 1ns/1ns
module acbi_dev_model (
    input wire logic chip_select_n,
    input wire logic sample_hold_n,
    input wire logic read_n,
    input wire logic channel_select_lo,
    input wire logic channel_select_hi,
    input wire logic [3:0][9:0] code_in,
    output logic done_n,
    output logic [9:0] result_bus
);
    logic [1:0] chan = 2'h0;
    logic [9:0] shown = 10'h000;
    logic tied = 1'b0;
    logic active = 1'b0;
    initial done_n = 1'b1;
    // Joined strobes fall in one time step in either order, so the mode is read a moment later.
    always @(negedge sample_hold_n) begin
        #1;
        if (!chip_select_n) begin
            chan = {channel_select_hi, channel_select_lo};
            tied = !read_n;
            active = !tied;
            if (tied) begin
                #850 done_n = 1'b0;
                #20 shown = code_in[chan];
            end
        end
    end
    always @(posedge sample_hold_n) if (active) begin
        active = 1'b0;
        #600 shown = code_in[chan];
        done_n = 1'b0;
    end
    always @(posedge read_n) done_n = 1'b1;
    // A released bus shows the inverse of its last value, so a stale read cannot match.
    assign result_bus = (!chip_select_n && !read_n) ? shown : ~shown;
endmodule : acbi_dev_model

// File: verif/acbi_host_monitor.sv
// Purpose: Pin-level checks on the host.
// Assumes: 10 ns mclk.
// Notes: Sees host ports only.
`timescale 1ns/1ns
module acbi_host_monitor #(
    parameter int TIMEOUT_CYC = 200
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic busy,
    input wire logic result_valid,
    input wire logic chip_select_n,
    input wire logic sample_hold_n,
    input wire logic read_n,
    input wire logic channel_select_lo,
    input wire logic channel_select_hi,
    input wire logic done_n
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic [7:0] lo_cnt;
    logic pend;
    always_ff @(posedge mclk) begin
        if (rst || sample_hold_n) lo_cnt <= 8'h00;
        else if (lo_cnt != 8'hFF) lo_cnt <= lo_cnt + 8'h01;
    end
    always_ff @(posedge mclk) begin
        if (rst) pend <= 1'b0;
        else if ($fell(sample_hold_n)) pend <= 1'b1;
        else if (!done_n) pend <= 1'b0;
    end
    chk_cs_sample: assert property (!sample_hold_n |-> !chip_select_n)
        else $error("sample strobe low without chip select");
    chk_cs_read: assert property (!read_n |-> !chip_select_n)
        else $error("read strobe low without chip select");
    chk_sample_width: assert property ($rose(sample_hold_n) && $past(read_n)
        |-> lo_cnt >= 8'h19)
        else $error("sample strobe too short");
    chk_select_hold: assert property (!sample_hold_n
        |-> $stable({channel_select_hi, channel_select_lo}))
        else $error("selects moved while sampling");
    chk_read_done: assert property ($fell(read_n) && sample_hold_n |-> !done_n)
        else $error("read before done");
    chk_tied_pair: assert property ($rose(sample_hold_n) && !$past(read_n)
        |-> $rose(read_n))
        else $error("joined strobes released apart");
    chk_one_start: assert property ($fell(sample_hold_n) |-> !pend)
        else $error("new start before done");
    chk_sample_busy: assert property (!sample_hold_n |-> busy)
        else $error("sampling while not busy");
    cov_sep: cover property ($fell(read_n) && sample_hold_n);
    cov_tied: cover property ($fell(read_n) && $fell(sample_hold_n));
    cov_valid: cover property (result_valid);
endmodule : acbi_host_monitor
bind acbi_host acbi_host_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) acbi_host_monitor_i (
    .mclk(mclk), .rst(rst), .busy(busy), .result_valid(result_valid),
    .chip_select_n(chip_select_n), .sample_hold_n(sample_hold_n), .read_n(read_n),
    .channel_select_lo(channel_select_lo), .channel_select_hi(channel_select_hi),
    .done_n(done_n));

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the converter host.
// Assumes: Inputs driven at falling mclk.
// Notes: Codes 0 and 1023 cover the scale ends.
`timescale 1ns/1ns
module tb_top;
    logic mclk = 1'b0, rst = 1'b1, start = 1'b0, tied_mode = 1'b0;
    logic [1:0] channel = 2'h0;
    logic busy, valid, tmo, cs_n, sh_n, rd_n, s_lo, s_hi, done_n;
    logic [9:0] result, bus;
    logic [3:0][9:0] codes = {10'h2AA, 10'h155, 10'h3FF, 10'h000};
    int miscompares = 0, samples_checked = 0;
    initial forever #5 mclk = ~mclk;
    acbi_host #(.TIMEOUT_CYC(150)) acbi_host_i (.mclk(mclk), .rst(rst), .start(start),
        .tied_mode(tied_mode), .channel(channel), .busy(busy), .result_valid(valid),
        .result(result), .timeout(tmo), .chip_select_n(cs_n), .sample_hold_n(sh_n),
        .read_n(rd_n), .channel_select_lo(s_lo), .channel_select_hi(s_hi),
        .done_n(done_n), .result_bus(bus));
    acbi_dev_model acbi_dev_model_i (.chip_select_n(cs_n), .sample_hold_n(sh_n),
        .read_n(rd_n), .channel_select_lo(s_lo), .channel_select_hi(s_hi),
        .code_in(codes), .done_n(done_n), .result_bus(bus));
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // A second start in mid-conversion must not yield a second result.
    task automatic run(input logic tm, input logic [1:0] ch, input logic again);
        int i;
        int n;
        int t;
        @(negedge mclk);
        start = 1'b1;
        tied_mode = tm;
        channel = ch;
        @(negedge mclk);
        start = 1'b0;
        n = 0;
        t = 0;
        for (i = 0; i < 600 && busy !== 1'b0; i++) begin
            start = again && i == 30;
            @(negedge mclk);
            if (valid === 1'b1) n++;
            if (tmo !== 1'b0) t++;
        end
        if (i == 600) begin
            miscompares++;
            final_report();
        end
        check(result, codes[ch]);
        check({8'h00, s_hi, s_lo}, {8'h00, ch});
        check(10'(n), 10'h001);
        check(10'(t), 10'h000);
    endtask : run
    task automatic scen_separate;
        for (int c = 0; c < 4; c++) run(1'b0, 2'(c), 1'b0);
    endtask : scen_separate
    task automatic scen_tied;
        int i;
        fork
            run(1'b1, 2'h1, 1'b0);
            begin
                for (i = 0; i < 50 && rd_n !== 1'b0; i++) @(negedge mclk);
                check(bus, 10'h2AA);
            end
        join
    endtask : scen_tied
    task automatic scen_refused;
        run(1'b0, 2'h2, 1'b1);
    endtask : scen_refused
    initial begin
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        scen_separate();
        scen_tied();
        scen_refused();
        final_report();
    end
endmodule : tb_top
